// file: common/pld_defines.vh
`ifndef PLD_DEFINES_VH
`define PLD_DEFINES_VH
// Register indexes (PROBE gives index bits [7:2]); byte address is four times the index
`define PLD_R_MON 12'h005
`define PLD_R_MAINT 8'h2b
`define PLD_R_PCTL 8'h71
`define PLD_R_PSTS 8'h72
`define PLD_R_PIND 8'h73
`define PLD_R_TCFG 8'hc7
`define PLD_R_SUBST 8'hcb
`define PLD_R_PROBE 6'h34
`define PLD_R_SMODE 8'hf0
// Reset values
`define PLD_RST_MON 4'h0
`define PLD_RST_MAINT 5'h00
`define PLD_RST_PCTL 4'h0
`define PLD_RST_PSTS 2'h0
`define PLD_RST_PIND 2'h0
`define PLD_RST_TCFG 4'h0
`define PLD_RST_SUBST 6'h00
`define PLD_RST_SMODE 4'h0
`define PLD_RST_PROBE 32'h00000000
`define PLD_SEED 20'hfffff
// Field positions
`define PLD_B_GFLIP 2
`define PLD_B_DFLIP 3
`define PLD_B_SEI 4
`define PLD_B_LOCK 4
`define PLD_B_RUN 0
`define PLD_B_DIR 1
// Encodings
`define PLD_FR_8BIT 2'h1
`define PLD_FR_7BIT 2'h2
`define PLD_KIND_15 2'h1
`define PLD_KIND_20 2'h2
`define PLD_SUBST_PL 3'h1
// Lock window
`define PLD_WIN_BITS 6'h30
`define PLD_ERR_MAX 4'ha
`endif

// file: core/pld_top.v
`include "pld_defines.vh"

module pld_top #(
  parameter NL = 8, // number of links
  parameter [5:0] WIN = `PLD_WIN_BITS, // lock window bits
  parameter [3:0] EMAX = `PLD_ERR_MAX // errors tolerated
) (
  input wire pclk, // bus and logic clock
  input wire presetn, // async reset, active low
  input wire psel, // APB select
  input wire penable, // APB enable
  input wire pwrite, // APB direction
  input wire [13:0] paddr, // APB byte address
  input wire [31:0] pwdata, // APB write data
  output reg [31:0] prdata, // APB read data
  output reg pready, // APB ready
  output reg pslverr, // APB error, unmapped
  input wire [NL-1:0] link_clk, // link bit clock
  input wire [NL-1:0] link_frame, // first bit of frame
  input wire [NL-1:0] rx_line_data, // data from line
  input wire [NL-1:0] tx_buf_data, // transmit buffer out
  input wire [NL-1:0] rx_ja_data, // receive attenuator out
  input wire [NL-1:0] tx_ja_data, // transmit attenuator out
  input wire [NL-1:0] rx_proc_data, // elastic store data
  input wire [NL-1:0] rx_proc_sig, // elastic store sig
  input wire [NL-1:0] tx_system_data, // backplane data
  input wire [NL-1:0] tx_system_signaling, // backplane sig
  input wire [NL-1:0] rx_system_clock_i, // pin level
  input wire [NL-1:0] rx_system_frame_pulse_i, // pin level
  input wire [NL-1:0] tx_system_clock_i, // pin level
  input wire [NL-1:0] tx_system_frame_pulse_i, // pin level
  input wire [NL-1:0] int_rx_clock, // own rx timing
  input wire [NL-1:0] int_rx_frame, // own rx frame
  input wire [NL-1:0] int_tx_clock, // own tx timing
  input wire [NL-1:0] int_tx_frame, // own tx frame
  output wire [NL-1:0] rx_system_data, // to backplane
  output wire [NL-1:0] rx_system_signaling, // to backplane
  output wire [NL-1:0] tx_payload_data, // into tx path
  output wire [NL-1:0] tx_payload_signaling, // into tx path
  output wire [NL-1:0] frame_proc_in, // rx framer input
  output wire [NL-1:0] rx_ja_in, // rx attenuator input
  output wire [NL-1:0] tx_ja_in, // tx attenuator input
  output wire [NL-1:0] rx_system_clock_o, // pin drive
  output wire [NL-1:0] rx_system_clock_oe, // pin enable
  output wire [NL-1:0] rx_system_frame_pulse_o, // pin drive
  output wire [NL-1:0] rx_system_frame_pulse_oe, // enable
  output wire [NL-1:0] tx_system_clock_o, // pin drive
  output wire [NL-1:0] tx_system_clock_oe, // pin enable
  output wire [NL-1:0] tx_system_frame_pulse_o, // pin drive
  output wire [NL-1:0] tx_system_frame_pulse_oe, // enable
  output wire [NL-1:0] bit_error_event, // to perf monitor
  output reg irq_n // interrupt, active low
);

  localparam NG = 18;
  localparam NO = 16;
  localparam [5:0] WEND = WIN - 6'h01;

  // Every pin and foreign-clock input passes two flops
  wire [NG*NL-1:0] pin_raw = {int_tx_frame, int_tx_clock,
    int_rx_frame, int_rx_clock, tx_system_frame_pulse_i,
    tx_system_clock_i, rx_system_frame_pulse_i,
    rx_system_clock_i, tx_system_signaling, tx_system_data,
    rx_proc_sig, rx_proc_data, tx_ja_data, rx_ja_data,
    tx_buf_data, rx_line_data, link_frame, link_clk};
  reg [NG*NL-1:0] meta_r;
  reg [NG*NL-1:0] sync_r;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_r <= {NG*NL{1'b0}};
      sync_r <= {NG*NL{1'b0}};
    end else begin
      meta_r <= pin_raw;
      sync_r <= meta_r;
    end
  end

  wire [NL-1:0] lclk_s = sync_r[0*NL +: NL];
  wire [NL-1:0] lfrm_s = sync_r[1*NL +: NL];
  wire [NL-1:0] line_s = sync_r[2*NL +: NL];
  wire [NL-1:0] tbuf_s = sync_r[3*NL +: NL];
  wire [NL-1:0] rja_s = sync_r[4*NL +: NL];
  wire [NL-1:0] tja_s = sync_r[5*NL +: NL];
  wire [NL-1:0] rpd_s = sync_r[6*NL +: NL];
  wire [NL-1:0] rps_s = sync_r[7*NL +: NL];
  wire [NL-1:0] tsd_s = sync_r[8*NL +: NL];
  wire [NL-1:0] tss_s = sync_r[9*NL +: NL];
  wire [NL-1:0] rck_s = sync_r[10*NL +: NL];
  wire [NL-1:0] rfp_s = sync_r[11*NL +: NL];
  wire [NL-1:0] tck_s = sync_r[12*NL +: NL];
  wire [NL-1:0] tfp_s = sync_r[13*NL +: NL];
  wire [NL-1:0] irc_s = sync_r[14*NL +: NL];
  wire [NL-1:0] irf_s = sync_r[15*NL +: NL];
  wire [NL-1:0] itc_s = sync_r[16*NL +: NL];
  wire [NL-1:0] itf_s = sync_r[17*NL +: NL];

  // Bus decode
  wire [11:0] idx = paddr[13:2];
  wire [7:0] off = idx[7:0];
  wire [2:0] lsel = idx[10:8];
  wire setup = psel & ~penable;
  wire wr_en = psel & penable & pready & pwrite;
  wire [8*NL-1:0] lrd_all;
  wire [NL-1:0] lhit_all;
  wire [NO*NL-1:0] out_nxt;
  wire [NL-1:0] irq_all;
  reg [NO*NL-1:0] out_r;
  reg [3:0] mon_r;

  wire ghit = idx == `PLD_R_MON;
  wire lhit = ~idx[11] & (lsel < NL) & lhit_all[lsel];
  wire [7:0] rd_nxt = ghit ? {4'h0, mon_r} :
    lhit ? lrd_all[{lsel, 3'h0} +: 8] : 8'h00;

  // Zero wait states: ready is raised for the access phase
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
      mon_r <= `PLD_RST_MON;
      irq_n <= 1'b1;
      out_r <= {NO*NL{1'b0}};
    end else begin
      pready <= setup;
      if (setup) begin
        prdata <= {24'h000000, rd_nxt};
        pslverr <= ~(ghit | lhit);
      end
      if (wr_en & ghit) begin
        mon_r <= pwdata[3:0];
      end
      irq_n <= ~(|irq_all);
      out_r <= out_nxt;
    end
  end

  assign rx_system_data = out_r[0*NL +: NL];
  assign rx_system_signaling = out_r[1*NL +: NL];
  assign tx_payload_data = out_r[2*NL +: NL];
  assign tx_payload_signaling = out_r[3*NL +: NL];
  assign frame_proc_in = out_r[4*NL +: NL];
  assign rx_ja_in = out_r[5*NL +: NL];
  assign tx_ja_in = out_r[6*NL +: NL];
  assign rx_system_clock_o = out_r[7*NL +: NL];
  assign rx_system_clock_oe = out_r[8*NL +: NL];
  assign rx_system_frame_pulse_o = out_r[9*NL +: NL];
  assign rx_system_frame_pulse_oe = out_r[10*NL +: NL];
  assign tx_system_clock_o = out_r[11*NL +: NL];
  assign tx_system_clock_oe = out_r[12*NL +: NL];
  assign tx_system_frame_pulse_o = out_r[13*NL +: NL];
  assign tx_system_frame_pulse_oe = out_r[14*NL +: NL];
  assign bit_error_event = out_r[15*NL +: NL];

  // Feedback taps of the three sequences
  function fb_of;
    input [19:0] s;
    input [1:0] k;
    begin
      case (k)
        `PLD_KIND_15: fb_of = s[14] ^ s[13];
        `PLD_KIND_20: fb_of = s[19] ^ s[16];
        default: fb_of = s[10] ^ s[8];
      endcase
    end
  endfunction

  // Link 0 observer source
  wire mon_on = (mon_r[2:0] != 3'h0) & (mon_r[2:0] < NL);
  wire mon_bit = mon_r[3] ? tbuf_s[mon_r[2:0]] :
    line_s[mon_r[2:0]];

  genvar i;
  generate
    for (i = 0; i < NL; i = i + 1) begin : g_link
      localparam [2:0] LID = i;
      reg [4:0] maint_r;
      reg [3:0] pctl_r;
      reg [1:0] psts_r;
      reg [1:0] ind_r;
      reg [3:0] tcfg_r;
      reg [5:0] subst_r;
      reg [3:0] smode_r;
      reg [31:0] probe_r;
      reg run_d_r;
      reg lclk_d_r;
      reg [7:0] bcnt_r;
      reg slot_r;
      reg [19:0] lfsr_r;
      reg ins_r;
      reg gbit_r;
      reg [19:0] det_r;
      reg lock_r;
      reg lock_d_r;
      reg [5:0] wcnt_r;
      reg [3:0] ecnt_r;
      reg berr_r;
      reg [7:0] lrd;
      reg lh;

      wire lw = wr_en & ~idx[11] & (lsel == LID);
      wire run = tcfg_r[`PLD_B_RUN];
      wire dir = tcfg_r[`PLD_B_DIR];
      wire [1:0] fr = tcfg_r[3:2];
      wire [1:0] kind = pctl_r[1:0];
      wire start = run & ~run_d_r;
      wire stb = lclk_s[i] & ~lclk_d_r;
      wire [7:0] bnext = lfrm_s[i] ? 8'h00 : bcnt_r + 8'h01;
      wire chan = (fr == `PLD_FR_8BIT) | (fr == `PLD_FR_7BIT);
      // Bit 7 of a channel is its last, lowest bit
      wire slot = ~chan | (probe_r[bnext[7:3]] &
        ((fr == `PLD_FR_8BIT) | (bnext[2:0] != 3'h7)));
      wire step = stb & slot & run;
      wire gfb = fb_of(lfsr_r, kind);
      wire sei = lw & (off == `PLD_R_PCTL) & pwdata[`PLD_B_SEI];
      wire dsrc = dir ? tsd_s[i] : rpd_s[i];
      wire dbit = dsrc ^ pctl_r[`PLD_B_DFLIP];
      wire err = dbit ^ fb_of(det_r, kind);
      wire [3:0] esum = (ecnt_r == 4'hf) ? ecnt_r :
        ecnt_r + {3'h0, err};
      wire berr = step & lock_r & err;
      wire lchg = lock_r ^ lock_d_r;

      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          maint_r <= `PLD_RST_MAINT;
          pctl_r <= `PLD_RST_PCTL;
          psts_r <= `PLD_RST_PSTS;
          ind_r <= `PLD_RST_PIND;
          tcfg_r <= `PLD_RST_TCFG;
          subst_r <= `PLD_RST_SUBST;
          smode_r <= `PLD_RST_SMODE;
          probe_r <= `PLD_RST_PROBE;
          run_d_r <= 1'b0;
          lclk_d_r <= 1'b0;
          bcnt_r <= 8'h00;
          slot_r <= 1'b0;
          lfsr_r <= `PLD_SEED;
          ins_r <= 1'b0;
          gbit_r <= 1'b0;
          det_r <= 20'h00000;
          lock_r <= 1'b0;
          lock_d_r <= 1'b0;
          wcnt_r <= 6'h00;
          ecnt_r <= 4'h0;
          berr_r <= 1'b0;
        end else begin
          if (lw) begin
            case (off)
              `PLD_R_MAINT: maint_r <= pwdata[4:0];
              `PLD_R_PCTL: pctl_r <= pwdata[3:0];
              `PLD_R_PSTS: psts_r <= pwdata[1:0];
              `PLD_R_TCFG: tcfg_r <= pwdata[3:0];
              `PLD_R_SUBST: subst_r <= pwdata[5:0];
              `PLD_R_SMODE: smode_r <= pwdata[3:0];
              default: begin
                if (off[7:2] == `PLD_R_PROBE) begin
                  probe_r[{off[1:0], 3'h0} +: 8] <= pwdata[7:0];
                end
              end
            endcase
          end
          // A new event wins over a clearing write
          ind_r[0] <= berr | (ind_r[0] & ~(lw &
            (off == `PLD_R_PIND) & pwdata[0]));
          ind_r[1] <= lchg | (ind_r[1] & ~(lw &
            (off == `PLD_R_PIND) & pwdata[1]));
          run_d_r <= run;
          lclk_d_r <= lclk_s[i];
          lock_d_r <= lock_r;
          berr_r <= berr;
          if (stb) begin
            bcnt_r <= bnext;
            slot_r <= slot;
          end
          // Pending error survives until a pattern bit takes it or run is cleared
          ins_r <= run & (sei | (ins_r & ~step));
          if (start) begin
            lfsr_r <= `PLD_SEED;
            det_r <= 20'h00000;
            lock_r <= 1'b0;
            wcnt_r <= 6'h00;
            ecnt_r <= 4'h0;
          end else if (step) begin
            lfsr_r <= {lfsr_r[18:0], gfb};
            gbit_r <= gfb ^ pctl_r[`PLD_B_GFLIP] ^ ins_r;
            // Self-synchronising: the detector shifts in data
            det_r <= {det_r[18:0], dbit};
            if (wcnt_r == WEND) begin
              wcnt_r <= 6'h00;
              ecnt_r <= 4'h0;
              if (!lock_r && esum == 4'h0) begin
                lock_r <= 1'b1;
              end else if (lock_r && esum > EMAX) begin
                lock_r <= 1'b0;
              end
            end else begin
              wcnt_r <= wcnt_r + 6'h01;
              ecnt_r <= esum;
            end
          end
        end
      end

      always @* begin
        lrd = 8'h00;
        lh = 1'b1;
        case (off)
          `PLD_R_MAINT: lrd = {3'h0, maint_r};
          `PLD_R_PCTL: lrd = {4'h0, pctl_r};
          `PLD_R_PSTS: lrd = {3'h0, lock_r, 2'h0, psts_r};
          `PLD_R_PIND: lrd = {6'h00, ind_r};
          `PLD_R_TCFG: lrd = {4'h0, tcfg_r};
          `PLD_R_SUBST: lrd = {2'h0, subst_r};
          `PLD_R_SMODE: lrd = {4'h0, smode_r};
          default: begin
            if (off[7:2] == `PLD_R_PROBE) begin
              lrd = probe_r[{off[1:0], 3'h0} +: 8];
            end else begin
              lh = 1'b0;
            end
          end
        endcase
      end

      assign lrd_all[8*i +: 8] = lrd;
      assign lhit_all[i] = lh;
      assign irq_all[i] = (ind_r[0] & psts_r[0]) |
        (ind_r[1] & psts_r[1]);

      // Loop routing
      wire sysok = (smode_r[0] ^ smode_r[1]) &
        ~smode_r[2] & ~smode_r[3];
      wire srl = maint_r[0] & sysok;
      wire sll = maint_r[1] & sysok;
      wire rxm = smode_r[0];
      wire txm = smode_r[1];
      wire pl = (subst_r[2:0] == `PLD_SUBST_PL) |
        ((subst_r[5:3] == `PLD_SUBST_PL) & probe_r[bcnt_r[7:3]]);
      wire gen_rx = run & dir & slot_r;
      wire gen_tx = run & ~dir & slot_r;
      wire line_i = (i == 0 && mon_on) ? mon_bit : line_s[i];
      wire rck_o = (srl & rxm) ? tck_s[i] :
        (sll & txm) ? itc_s[i] : irc_s[i];
      wire rfp_o = (srl & rxm) ? tfp_s[i] :
        (sll & txm) ? itf_s[i] : irf_s[i];
      wire tck_o = (srl & txm) ? rck_s[i] :
        (sll & rxm) ? irc_s[i] : itc_s[i];
      wire tfp_o = (srl & txm) ? rfp_s[i] :
        (sll & rxm) ? irf_s[i] : itf_s[i];
      wire roe = rxm | (sll & txm);
      wire toe = txm | (sll & rxm);

      assign out_nxt[0*NL+i] = srl ? tsd_s[i] :
        gen_rx ? gbit_r : rpd_s[i];
      assign out_nxt[1*NL+i] = srl ? tss_s[i] : rps_s[i];
      assign out_nxt[2*NL+i] = (sll | pl) ? rpd_s[i] :
        gen_tx ? gbit_r : tsd_s[i];
      assign out_nxt[3*NL+i] = (sll | pl) ? rps_s[i] :
        tss_s[i];
      assign out_nxt[4*NL+i] = maint_r[2] ? tbuf_s[i] :
        line_i;
      assign out_nxt[5*NL+i] = maint_r[4] ? tja_s[i] :
        line_i;
      assign out_nxt[6*NL+i] = maint_r[3] ? rja_s[i] :
        tbuf_s[i];
      assign out_nxt[7*NL+i] = rck_o;
      assign out_nxt[8*NL+i] = roe;
      assign out_nxt[9*NL+i] = rfp_o;
      assign out_nxt[10*NL+i] = roe;
      assign out_nxt[11*NL+i] = tck_o;
      assign out_nxt[12*NL+i] = toe;
      assign out_nxt[13*NL+i] = tfp_o;
      assign out_nxt[14*NL+i] = toe;
      assign out_nxt[15*NL+i] = berr_r;
    end
  endgenerate

endmodule

// file: testbench/pld_far_model.sv
module pld_far_model #(
  parameter NL = 8
) (
  input wire loop_en, // return tx payload as rx data
  input wire [NL-1:0] tx_payload_data, // generator side
  output logic [NL-1:0] link_clk, // bit clock
  output logic [NL-1:0] link_frame, // frame start
  output logic [NL-1:0] rx_proc_data, // elastic store out
  output logic [15*NL-1:0] src // other streams
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [31:0] cnt;
  initial begin
    cnt = 32'h0;
    link_clk = '0;
    link_frame = '0;
    rx_proc_data = '0;
    src = '0;
  end
  // Line timing runs free, as a recovered clock does
  always #62.5 link_clk = ~link_clk;
  // Data moves on the falling edge, so it is settled at the rising one
  always @(negedge link_clk[0]) begin
    cnt <= cnt + 32'h1;
    link_frame <= {NL{cnt[7:0] == 8'hff}};
    rx_proc_data <= loop_en ? tx_payload_data : src[NL-1:0] ^ {NL{cnt[2]}};
    for (int k = 0; k < 15; k++)
      src[k*NL+:NL] <= NL'(((cnt + k) * (cnt * 2 + k * 37 + 1)) >> 3);
  end
endmodule

// file: testbench/pld_top_monitor.sv
module pld_top_monitor #(
  parameter NL = 8
) (
  input wire pclk, // clock
  input wire presetn, // reset, active low
  input wire psel, // select
  input wire penable, // enable
  input wire [31:0] prdata, // read data
  input wire pready, // ready
  input wire pslverr, // error
  input wire [NL-1:0] link_clk, // bit clock
  input wire [NL-1:0] bit_error_event // error pulse
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_answer;
    pready ##1 !pready;
  endsequence
  property p_ready_after_setup;
    s_setup |=> s_answer;
  endproperty
  a_ready_after_setup: assert property (p_ready_after_setup)
    else $error("ready missing after setup");
  property p_no_stray_ready;
    !(psel && !penable) |=> !pready;
  endproperty
  a_no_stray_ready: assert property (p_no_stray_ready)
    else $error("ready without setup");
  property p_rdata_hold;
    !(psel && !penable) |=> $stable(prdata) && $stable(pslverr);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold)
    else $error("read data moved outside setup");
  property p_upper_zero;
    pready |-> prdata[31:8] == 24'h000000;
  endproperty
  a_upper_zero: assert property (p_upper_zero)
    else $error("upper read data not zero");
  property p_err_zero;
    pslverr |-> prdata == 32'h00000000;
  endproperty
  a_err_zero: assert property (p_err_zero)
    else $error("error read returned data");
  property p_err_with_ready;
    $rose(pslverr) |-> pready;
  endproperty
  a_err_with_ready: assert property (p_err_with_ready)
    else $error("error raised outside access");
  property p_event_single;
    bit_error_event[0] |=> !bit_error_event[0] [*8];
  endproperty
  a_event_single: assert property (p_event_single)
    else $error("error event longer than one pulse");
  property p_event_in_bit;
    bit_error_event[0] |-> link_clk[0];
  endproperty
  a_event_in_bit: assert property (p_event_in_bit)
    else $error("error event away from bit edge");
endmodule

// file: testbench/prbs_loopback_diagnostics_bench.sv
`include "pld_defines.vh"
module prbs_loopback_diagnostics_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, loop_en = 1'b0;
  logic [13:0] paddr = 14'h0000;
  logic [31:0] pwdata = 32'h00000000;
  int n_mismatch = 0, check_count = 0;
  wire [31:0] prdata;
  wire pready, pslverr, irq_n;
  wire [119:0] src;
  wire [7:0] rx_system_data, tx_payload_data, frame_proc_in, rx_ja_in;
  wire [7:0] tx_ja_in, rx_system_clock_o, bit_error_event;
  wire [7:0] link_clk, link_frame, rx_proc_data;
  wire [7:0] rx_system_signaling, tx_payload_signaling, rx_system_clock_oe;
  wire [7:0] rx_system_frame_pulse_o, tx_system_clock_o;
  wire [7:0] rx_line_data = src[7:0], tx_buf_data = src[15:8],
    rx_ja_data = src[23:16], tx_ja_data = src[31:24],
    rx_proc_sig = src[39:32], tx_system_data = src[47:40],
    tx_system_signaling = src[55:48], rx_system_clock_i = src[63:56],
    rx_system_frame_pulse_i = src[71:64], tx_system_clock_i = src[79:72],
    tx_system_frame_pulse_i = src[87:80], int_rx_clock = src[95:88],
    int_rx_frame = src[103:96], int_tx_clock = src[111:104],
    int_tx_frame = src[119:112];
  pld_top #(.NL(8)) pld_top_inst (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .link_clk,
    .link_frame, .rx_line_data, .tx_buf_data, .rx_ja_data, .tx_ja_data,
    .rx_proc_data, .rx_proc_sig, .tx_system_data, .tx_system_signaling,
    .rx_system_clock_i, .rx_system_frame_pulse_i, .tx_system_clock_i,
    .tx_system_frame_pulse_i, .int_rx_clock, .int_rx_frame, .int_tx_clock,
    .int_tx_frame, .rx_system_data, .rx_system_signaling,
    .tx_payload_data, .tx_payload_signaling, .frame_proc_in, .rx_ja_in,
    .tx_ja_in, .rx_system_clock_o, .rx_system_clock_oe,
    .rx_system_frame_pulse_o, .rx_system_frame_pulse_oe(),
    .tx_system_clock_o, .tx_system_clock_oe(),
    .tx_system_frame_pulse_o(), .tx_system_frame_pulse_oe(),
    .bit_error_event, .irq_n);
  pld_far_model #(.NL(8)) pld_far_model_inst (.loop_en, .tx_payload_data,
    .link_clk, .link_frame, .rx_proc_data, .src);
  always #4 pclk = ~pclk;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // Entered just after a rising edge; returns one edge after the access
  task automatic xfer(input logic w, input logic [11:0] idx,
      input logic [7:0] d, output logic [31:0] q, output logic e);
    int t;
    t = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      t++;
    end while (pready !== 1'b1 && t < 50);
    if (t == 50)
      n_mismatch++;
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [11:0] idx, input logic [7:0] d);
    logic [31:0] q;
    logic e;
    xfer(1'b1, idx, d, q, e);
  endtask
  task automatic rchk(input logic [11:0] idx, input logic [31:0] exp);
    logic [31:0] q;
    logic e;
    xfer(1'b0, idx, 8'h00, q, e);
    check(q, exp);
  endtask
  // Polls instead of waiting a fixed time: lock delay depends on the seed
  task automatic wait_lock(input logic v);
    logic [31:0] q;
    logic e;
    for (int j = 0; j < 400; j++) begin
      xfer(1'b0, `PLD_R_PSTS, 8'h00, q, e);
      if (q[`PLD_B_LOCK] === v)
        break;
      repeat (30) @(posedge pclk);
    end
    check(q[`PLD_B_LOCK], v);
  endtask
  task automatic route(input logic [11:0] idx, input logic [7:0] v,
      input int s);
    logic [7:0] got, exp;
    wr(idx, v);
    repeat (2) @(posedge link_clk[0]);
    for (int i = 0; i < 8; i++) begin
      @(posedge link_clk[0]);
      got = {tx_payload_data[0], frame_proc_in[0], tx_ja_in[0], rx_ja_in[0],
        frame_proc_in[0], rx_system_data[0], tx_payload_data[0],
        rx_system_data[0]};
      exp = {tx_system_data[0], tx_buf_data[1], rx_ja_data[0],
        tx_ja_data[0], tx_buf_data[0], rx_proc_data[0], rx_proc_data[0],
        tx_system_data[0]};
      check(got[s], exp[s]);
      if (s == 0) begin
        check(rx_system_clock_o[0], tx_system_clock_i[0]);
        check(rx_system_frame_pulse_o[0],
          tx_system_frame_pulse_i[0]);
        check(rx_system_signaling[0], tx_system_signaling[0]);
        check(rx_system_clock_oe[0], 1'b1);
      end
      if (s == 1)
        check(tx_payload_signaling[0], rx_proc_sig[0]);
      // Only the local loop (rx master) routes own rx timing to the tx clock
      if (s == 1 && idx == `PLD_R_MAINT)
        check(tx_system_clock_o[0], int_rx_clock[0]);
    end
  endtask
  // Accepts the recurrence of the polynomial or of its reciprocal
  task automatic seq_chk(input int a, input int b, input logic use_rx);
    logic [95:0] s;
    int e1, e2;
    e1 = 0;
    e2 = 0;
    for (int i = 0; i < 96; i++) begin
      @(posedge link_clk[0]);
      s[i] = use_rx ? rx_system_data[0] : tx_payload_data[0];
    end
    for (int i = 56; i < 96; i++) begin
      e1 += s[i] ^ s[i-a] ^ s[i-b];
      e2 += s[i] ^ s[i-a] ^ s[i-a+b];
    end
    check({31'h0, e1 == 0 || e2 == 0}, 32'h1);
  endtask
  int ta[3] = '{11, 15, 20};
  int tb[3] = '{9, 14, 17};
  logic [31:0] q;
  logic e;
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rchk(`PLD_R_PCTL, 32'h0);
    rchk(`PLD_R_PSTS, 32'h0);
    rchk(`PLD_R_PIND, 32'h0);
    rchk(`PLD_R_TCFG, 32'h0);
    rchk(`PLD_R_MAINT, 32'h0);
    xfer(1'b0, 12'h0ff, 8'h00, q, e);
    check(e, 1'b1);
    wr(`PLD_R_PCTL, 8'h1f);
    rchk(`PLD_R_PCTL, 32'h0f);
    wr(`PLD_R_SMODE, 8'h01);
    route(`PLD_R_MAINT, 8'h01, 0);
    route(`PLD_R_MAINT, 8'h02, 1);
    wr(`PLD_R_SMODE, 8'h03);
    route(`PLD_R_MAINT, 8'h01, 2);
    route(`PLD_R_MAINT, 8'h04, 3);
    route(`PLD_R_MAINT, 8'h10, 4);
    route(`PLD_R_MAINT, 8'h08, 5);
    wr(`PLD_R_MAINT, 8'h00);
    route(`PLD_R_SUBST, 8'h01, 1);
    wr(`PLD_R_SUBST, 8'h00);
    route(`PLD_R_MON, 8'h09, 6);
    wr(`PLD_R_MON, 8'h00);
    loop_en <= 1'b1;
    wr(`PLD_R_TCFG, 8'h01);
    for (int k = 0; k < 3; k++) begin
      wr(`PLD_R_PCTL, 8'(k));
      seq_chk(ta[k], tb[k], 1'b0);
      wait_lock(1'b1);
    end
    wr(`PLD_R_PIND, 8'h03);
    rchk(`PLD_R_PIND, 32'h0);
    wr(`PLD_R_PSTS, 8'h01);
    wr(`PLD_R_PCTL, 8'h12);
    repeat (4) @(posedge link_clk[0]);
    rchk(`PLD_R_PIND, 32'h1);
    rchk(`PLD_R_PSTS, 32'h11);
    check(irq_n, 1'b0);
    wr(`PLD_R_PIND, 8'h01);
    repeat (2) @(posedge pclk);
    check(irq_n, 1'b1);
    wr(`PLD_R_PSTS, 8'h00);
    wr(`PLD_R_PCTL, 8'h06);
    wait_lock(1'b0);
    rchk(`PLD_R_PIND, 32'h3);
    wr(`PLD_R_PCTL, 8'h0e);
    wait_lock(1'b1);
    wr(`PLD_R_PCTL, 8'h00);
    wr(`PLD_R_TCFG, 8'h03);
    seq_chk(11, 9, 1'b1);
    route(`PLD_R_TCFG, 8'h05, 7);
    route(`PLD_R_TCFG, 8'h09, 7);
    for (int j = 0; j < 4; j++)
      wr({`PLD_R_PROBE, 2'(j)}, 8'hff);
    rchk({`PLD_R_PROBE, 2'h3}, 32'hff);
    wr(`PLD_R_TCFG, 8'h05);
    seq_chk(11, 9, 1'b0);
    tally_and_finish;
  end
  initial begin
    repeat (90000) @(posedge pclk);
    n_mismatch++;
    tally_and_finish;
  end
endmodule
bind pld_top pld_top_monitor #(.NL(NL)) pld_top_monitor_inst (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .link_clk(link_clk), .bit_error_event(bit_error_event));
